// File: rtl/crs_core.sv
/*
 * Processor register set with word memory, wrap-around addressing,
 * zero reads and dropped writes beyond installed memory, even parity.
 * Assumes one clock, synchronous reset, Avalon-MM master on the bus.
 */
`timescale 1ns/1ps
`default_nettype none
`include "crs_regs.svh"

// Function
// (RULE1) 24-bit main accumulator visible to software
// (RULE2) 24-bit extension accumulator, low half
// (RULE3) Three index registers: 15-bit base, 9-bit increment
// (RULE4) Program counter steps by one per instruction
// (RULE5) Six-bit flag register, bit 0 overflow
// (RULE6) Each flag set, cleared and testable
// (RULE7) Operand buffer holds memory data words
// (RULE8) Instruction buffer latches fetched words
// (RULE9) Memory address register for all accesses
// (RULE10) Opcode register holds current operation code
// (RULE11) Optional 15-bit main accumulator extension
// (RULE12) Optional 15-bit extension accumulator extension
// (RULE13) Memory words: 24 data plus parity
// (RULE14) Address space wraps from 77777 to 0
// (RULE15) Reads beyond installed memory return zero
// (RULE16) Writes beyond installed memory change nothing
// (RULE17) Even parity generated on store, checked on fetch
// (RULE18) Bit 0 is the word's most significant
// (RULE19) Reset clears every register to zero; MEMCFG resets to the top installed address instead
module crs_core
    import crs_pkg::*;
#(
    parameter int MEM_WORDS = 4096,
    parameter bit FP_FITTED = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Status
    output logic [5:0] flag_out,
    output logic parity_err,
    output logic irq
);

    // ==================================================
    // Helpers
    function automatic logic even_par(input logic [23:0] w);
        even_par = ^w; // Makes 25-bit word even
    endfunction

    // Zero-extend a 15-bit field to a 24-bit word
    function automatic logic [23:0] zx15(input logic [14:0] v);
        zx15 = {9'h000, v};
    endfunction

    // ==================================================
    // State
    logic [23:0] acc_r, ext_r, opnd_r, insn_r;
    logic [23:0] idx_r [0:2];
    logic [14:0] pc_r, maddr_r, fpa_r, fpb_r;
    logic [5:0] flag_r, opc_r;
    logic [24:0] mem [0:MEM_WORDS-1];
    logic [24:0] mem_q;
    logic [14:0] limit_r;
    logic [2:0] irq_stat_r, irq_en_r;
    crs_state_t st_r;
    crs_cmd_t cmd_r;
    logic fp_active_r;
    logic [1:0] lat_r;
    logic in_range;
    logic wr_hit;
    logic [31:0] rd_nxt;

    // Limit holds the top installed address, so that address itself is still fitted
    assign in_range = (maddr_r <= limit_r); // [RULE15] [RULE16]
    // A write lands only at the edge where the master sees waitrequest low
    assign wr_hit = avs_write && !avs_waitrequest;

    // ==================================================
    // Bus handshake: one wait cycle, answer on the second edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(avs_read || avs_write);
        end
    end

    // Read mux, registered so data stands with waitrequest low
    always_comb begin
        rd_nxt = 32'h00000000;
        case (avs_address)
            `CRS_OFF_ACC: rd_nxt = {8'h00, acc_r};
            `CRS_OFF_EXT: rd_nxt = {8'h00, ext_r};
            `CRS_OFF_IDX1: rd_nxt = {8'h00, idx_r[0]};
            `CRS_OFF_IDX2: rd_nxt = {8'h00, idx_r[1]};
            `CRS_OFF_IDX3: rd_nxt = {8'h00, idx_r[2]};
            `CRS_OFF_PC: rd_nxt = {17'h00000, pc_r};
            `CRS_OFF_FLAG: rd_nxt = {26'h0000000, flag_r};
            `CRS_OFF_OPND: rd_nxt = {8'h00, opnd_r};
            `CRS_OFF_INSN: rd_nxt = {8'h00, insn_r};
            `CRS_OFF_MADDR: rd_nxt = {17'h00000, maddr_r};
            `CRS_OFF_OPC: rd_nxt = {26'h0000000, opc_r};
            `CRS_OFF_FPA: rd_nxt = {17'h00000, fpa_r};
            `CRS_OFF_FPB: rd_nxt = {17'h00000, fpb_r};
            `CRS_OFF_CMD: rd_nxt = {28'h0000000, fp_active_r, st_r};
            `CRS_OFF_IRQ_STAT: rd_nxt = {29'h00000000, irq_stat_r};
            `CRS_OFF_IRQ_EN: rd_nxt = {29'h00000000, irq_en_r};
            `CRS_OFF_MEMCFG: rd_nxt = {17'h00000, limit_r};
            default: rd_nxt = 32'h00000000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_nxt;
        end
    end

    // ==================================================
    // Programmer-visible registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            acc_r <= `CRS_RST_ZERO; // [RULE19]
            ext_r <= `CRS_RST_ZERO;
            idx_r[0] <= `CRS_RST_ZERO;
            idx_r[1] <= `CRS_RST_ZERO;
            idx_r[2] <= `CRS_RST_ZERO;
        end else if (st_r == CRS_OPRD && lat_r == 2'd0 && cmd_r == CRS_CMD_LOAD) begin
            acc_r <= in_range ? mem_q[23:0] : `CRS_RST_ZERO; // [RULE1] [RULE15]
        end else if (wr_hit) begin
            case (avs_address)
                `CRS_OFF_ACC: acc_r <= avs_writedata[23:0]; // [RULE1]
                `CRS_OFF_EXT: ext_r <= avs_writedata[23:0]; // [RULE2]
                `CRS_OFF_IDX1: idx_r[0] <= avs_writedata[23:0]; // [RULE3]
                `CRS_OFF_IDX2: idx_r[1] <= avs_writedata[23:0]; // [RULE3]
                `CRS_OFF_IDX3: idx_r[2] <= avs_writedata[23:0]; // [RULE3]
                default: ;
            endcase
        end
    end

    // Flags: overflow at field position 0, which is vector bit 5 [RULE5] [RULE18]
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flag_r <= 6'h00;
        end else if (wr_hit && avs_address == `CRS_OFF_FLAG) begin
            flag_r <= avs_writedata[5:0];
        end else if (wr_hit && avs_address == `CRS_OFF_FLGSET) begin
            flag_r <= flag_r | avs_writedata[5:0]; // [RULE6]
        end else if (wr_hit && avs_address == `CRS_OFF_FLGCLR) begin
            flag_r <= flag_r & ~avs_writedata[5:0]; // [RULE6]
        end
    end

    // ==================================================
    // Sequencer: fetch (none for step), optional operand access, done
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r <= CRS_IDLE;
            cmd_r <= CRS_CMD_FETCH;
            lat_r <= 2'd0;
            fp_active_r <= 1'b0;
        end else begin
            case (st_r)
                CRS_IDLE: begin
                    if (wr_hit && avs_address == `CRS_OFF_CMD) begin
                        cmd_r <= crs_cmd_t'(avs_writedata[1:0]);
                        fp_active_r <= FP_FITTED & avs_writedata[2];
                        lat_r <= 2'(`CRS_MEM_LAT - 1);
                        st_r <= (avs_writedata[1:0] == 2'b11) ? CRS_DONE : CRS_FETCH;
                    end
                end
                CRS_FETCH: begin
                    if (lat_r != 2'd0) begin
                        lat_r <= lat_r - 2'd1;
                    end else begin
                        lat_r <= 2'(`CRS_MEM_LAT - 1);
                        case (cmd_r)
                            CRS_CMD_LOAD: st_r <= CRS_OPRD;
                            CRS_CMD_STORE: st_r <= CRS_OPWR;
                            default: st_r <= CRS_DONE;
                        endcase
                    end
                end
                CRS_OPRD: begin
                    if (lat_r != 2'd0) begin
                        lat_r <= lat_r - 2'd1;
                    end else begin
                        st_r <= CRS_DONE;
                    end
                end
                CRS_OPWR: st_r <= CRS_DONE;
                CRS_DONE: begin
                    st_r <= CRS_IDLE;
                    fp_active_r <= 1'b0; // [RULE11] [RULE12] Only during the instruction
                end
                default: st_r <= CRS_IDLE;
            endcase
        end
    end

    // Memory address register and program counter
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            maddr_r <= 15'h0000;
            pc_r <= 15'h0000;
        end else if (st_r == CRS_IDLE && wr_hit && avs_address == `CRS_OFF_CMD) begin
            maddr_r <= pc_r; // [RULE9] Instruction fetch address
        end else if (st_r == CRS_FETCH && lat_r == 2'd0) begin
            // Address field of the word arriving now; the buffer still holds the old one
            maddr_r <= in_range ? mem_q[14:0] : 15'h0000; // [RULE9] [RULE15]
        end else if (st_r == CRS_DONE) begin
            pc_r <= pc_r + 15'h0001; // [RULE4] [RULE14] 77777 wraps to 00000
        end else if (wr_hit && avs_address == `CRS_OFF_PC) begin
            pc_r <= avs_writedata[14:0]; // [RULE4]
        end else if (wr_hit && avs_address == `CRS_OFF_MADDR) begin
            maddr_r <= avs_writedata[14:0];
        end
    end

    // ==================================================
    // Core memory: read every cycle, write only when installed
    always_ff @(posedge sys_clk) begin
        mem_q <= mem[maddr_r % MEM_WORDS];
        if (st_r == CRS_OPWR && in_range) begin
            mem[maddr_r % MEM_WORDS] <= {even_par(opnd_r), opnd_r}; // [RULE13] [RULE16] [RULE17]
        end
    end

    // Hidden buffers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            insn_r <= `CRS_RST_ZERO;
            opnd_r <= `CRS_RST_ZERO;
            opc_r <= 6'h00;
            fpa_r <= 15'h0000;
            fpb_r <= 15'h0000;
        end else if (st_r == CRS_FETCH && lat_r == 2'd0) begin
            insn_r <= in_range ? mem_q[23:0] : `CRS_RST_ZERO; // [RULE8] [RULE15]
            opc_r <= in_range ? mem_q[20:15] : 6'h00; // [RULE10] [RULE18] Positions 3-8
        end else if (st_r == CRS_OPRD && lat_r == 2'd0) begin
            opnd_r <= in_range ? mem_q[23:0] : `CRS_RST_ZERO; // [RULE7]
        end else if (st_r == CRS_OPWR) begin
            fpa_r <= fp_active_r ? acc_r[14:0] : fpa_r; // [RULE11]
            fpb_r <= fp_active_r ? ext_r[14:0] : fpb_r; // [RULE12]
        end else if (wr_hit && avs_address == `CRS_OFF_OPND) begin
            opnd_r <= avs_writedata[23:0]; // [RULE7] Word to be stored
        end
    end

    // Installed size; out-of-range store still lets the sequence finish
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            limit_r <= 15'(MEM_WORDS - 1);
        end else if (wr_hit && avs_address == `CRS_OFF_MEMCFG) begin
            limit_r <= avs_writedata[14:0];
        end
    end

    // ==================================================
    // Events: 0 parity error, 1 instruction done, 2 operand access to missing memory
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_stat_r <= 3'h0;
            irq_en_r <= 3'h0;
            parity_err <= 1'b0;
            irq <= 1'b0;
            flag_out <= 6'h00;
        end else begin
            parity_err <= (st_r == CRS_FETCH || st_r == CRS_OPRD) && lat_r == 2'd0
                          && in_range && (^mem_q); // [RULE17]
            // Set wins over clear
            irq_stat_r <= (wr_hit && avs_address == `CRS_OFF_IRQ_CLR
                           ? irq_stat_r & ~avs_writedata[2:0] : irq_stat_r)
                          | {(st_r == CRS_OPRD || st_r == CRS_OPWR) && !in_range,
                             st_r == CRS_DONE, parity_err};
            if (wr_hit && avs_address == `CRS_OFF_IRQ_EN) begin
                irq_en_r <= avs_writedata[2:0];
            end
            irq <= |(irq_stat_r & irq_en_r);
            flag_out <= flag_r;
        end
    end

endmodule
`default_nettype wire

// File: rtl/crs_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * processor register set. Assumes an Avalon-MM slave with 32-bit words.
 */
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH

// ==================================================
// Byte offsets
`define CRS_OFF_ACC      8'h00
`define CRS_OFF_EXT      8'h04
`define CRS_OFF_IDX1     8'h08
`define CRS_OFF_IDX2     8'h0C
`define CRS_OFF_IDX3     8'h10
`define CRS_OFF_PC       8'h14
`define CRS_OFF_FLAG     8'h18
`define CRS_OFF_OPND     8'h1C
`define CRS_OFF_INSN     8'h20
`define CRS_OFF_MADDR    8'h24
`define CRS_OFF_OPC      8'h28
`define CRS_OFF_FPA      8'h2C
`define CRS_OFF_FPB      8'h30
`define CRS_OFF_CMD      8'h34
`define CRS_OFF_FLGSET   8'h38
`define CRS_OFF_FLGCLR   8'h3C
`define CRS_OFF_IRQ_STAT 8'h40
`define CRS_OFF_IRQ_EN   8'h44
`define CRS_OFF_IRQ_CLR  8'h48
`define CRS_OFF_MEMCFG   8'h4C

// ==================================================
// Fields, reset values, timing
`define CRS_OVF_BIT      5
`define CRS_IDX_INC_MSB  23
`define CRS_IDX_INC_LSB  15
`define CRS_IDX_BASE_MSB 14
`define CRS_RST_ZERO     24'h000000
`define CRS_MEM_LAT      2

`endif

// File: rtl/crs_pkg.sv
/*
 * Types of the processor register set block.
 * Assumes crs_regs.svh carries the numbers.
 */
package crs_pkg;
    typedef enum logic [2:0] {
        CRS_IDLE  = 3'b000,
        CRS_FETCH = 3'b001,
        CRS_OPRD  = 3'b010,
        CRS_OPWR  = 3'b011,
        CRS_DONE  = 3'b100
    } crs_state_t;

    typedef enum logic [1:0] {
        CRS_CMD_FETCH = 2'b00,
        CRS_CMD_LOAD  = 2'b01,
        CRS_CMD_STORE = 2'b10,
        CRS_CMD_STEP  = 2'b11
    } crs_cmd_t;
endpackage

// File: tb/crs_core_asserts.sv
/*
 * Checker for the processor register set, bound to crs_core.
 * Assumes it sees only the top ports and the offsets of crs_regs.svh.
 */
`timescale 1ns/1ps
`default_nettype none
`include "crs_regs.svh"

module crs_core_chk
    import crs_pkg::*;
#(
    parameter int MEM_WORDS = 4096,
    parameter bit FP_FITTED = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Status
    input wire logic [5:0] flag_out,
    input wire logic parity_err,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic [5:0] set_d_r;
    logic [5:0] clr_d_r;
    logic done_w;

    // ==================================================
    // Flag write data kept, since the master drops it after the answer
    assign done_w = !avs_waitrequest && avs_write;
    always_ff @(posedge sys_clk) begin
        if (done_w && avs_address == `CRS_OFF_FLGSET) set_d_r <= avs_writedata[5:0];
        if (done_w && avs_address == `CRS_OFF_FLGCLR) clr_d_r <= avs_writedata[5:0];
    end

    // ==================================================
    // Bus handshake steps
    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    property p_answer;
        s_take |=> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("access not answered after one cycle");
    property p_idle;
        !(avs_read || avs_write) |=> avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without a request");

    // ==================================================
    // Register widths seen on reads
    property p_rd_upper;
        !avs_waitrequest && avs_read |-> avs_readdata[31:24] == 8'h00;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read wider than a word");
    property p_pc_rd;
        !avs_waitrequest && avs_read && avs_address == `CRS_OFF_PC |-> avs_readdata[31:15] == 17'h0;
    endproperty
    a_pc_rd: assert property (p_pc_rd) else $error("counter wider than 15 bits");
    property p_flag_rd;
        !avs_waitrequest && avs_read && avs_address == `CRS_OFF_FLAG
            |-> avs_readdata == {26'h0, flag_out};
    endproperty
    a_flag_rd: assert property (p_flag_rd) else $error("flag read differs from flag port");

    // ==================================================
    // Flag set and clear within two cycles
    property p_flgset;
        done_w && avs_address == `CRS_OFF_FLGSET |-> ##[1:2] ((flag_out & set_d_r) == set_d_r);
    endproperty
    a_flgset: assert property (p_flgset) else $error("flag bits not set");
    property p_flgclr;
        done_w && avs_address == `CRS_OFF_FLGCLR |-> ##[1:2] ((flag_out & clr_d_r) == 6'h00);
    endproperty
    a_flgclr: assert property (p_flgclr) else $error("flag bits not cleared");

    // ==================================================
    // Parity pulse and reset values
    property p_par;
        parity_err |=> !parity_err;
    endproperty
    a_par: assert property (p_par) else $error("parity pulse too long");
    property p_rst;
        $fell(srst) |-> avs_waitrequest && flag_out == 6'h00 && !irq && !parity_err;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule

bind crs_core crs_core_chk #(.MEM_WORDS(MEM_WORDS), .FP_FITTED(FP_FITTED)) u_chk (
    .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flag_out(flag_out), .parity_err(parity_err),
    .irq(irq));
`default_nettype wire

// File: tb/crs_host.sv
/*
 * Host model: Avalon-MM master that issues one transfer per call.
 * Assumes the bench's cycle counter cuts short a slave that never answers.
 */
`timescale 1ns/1ps
`default_nettype none

module crs_host (
    // Clock
    input wire logic sys_clk,
    // Avalon-MM master
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    // ==================================================
    // Idle bus at time zero
    initial begin
        avs_address <= 8'h00;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= 32'h0;
    end

    // Request held until waitrequest is sampled low, then released
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/*
 * Self-checking bench of the processor register set.
 * Assumes crs_host as bus master and a 64-word memory for short runs.
 */
`timescale 1ns/1ps
`default_nettype none
`include "crs_regs.svh"

module tb_top;
    import crs_pkg::*;
    localparam int MW = 64;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} crs_row_t;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, parity_err, irq;
    logic [31:0] avs_writedata, avs_readdata, q, st;
    logic [5:0] flag_out;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    crs_row_t rows[9];

    // ==================================================
    // Clock, design and host
    always #2.5 sys_clk = ~sys_clk;
    crs_core #(.MEM_WORDS(MW), .FP_FITTED(1'b1)) dut (.sys_clk(sys_clk), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .flag_out(flag_out), .parity_err(parity_err),
        .irq(irq));
    crs_host host (.sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    // ==================================================
    // Compare, bus access and command tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, q);
        check(q, e);
    endtask
    // Clears status first so a stale done bit cannot end the poll early
    task automatic run(input logic [31:0] c);
        wr(`CRS_OFF_IRQ_CLR, 32'h7);
        wr(`CRS_OFF_CMD, c);
        st = 32'h0;
        while (st[1] !== 1'b1) host.xfer(1'b0, `CRS_OFF_IRQ_STAT, 32'h0, st);
    endtask
    // Puts word w at location 0 and the counter at 0; the fetch from 20 lies
    // beyond the installed size, so it reads zero and the store aims at 0
    task automatic aim(input logic [31:0] w);
        wr(`CRS_OFF_PC, 32'h20);
        wr(`CRS_OFF_OPND, w);
        run(32'h2);
        wr(`CRS_OFF_PC, 32'h0);
    endtask
    task automatic conclude();
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    // ==================================================
    // Main sequence
    initial begin
        rows = '{'{`CRS_OFF_ACC, 32'hFFFFFFFF, 32'h00FFFFFF},
                 '{`CRS_OFF_EXT, 32'hFF5A5A5A, 32'h005A5A5A},
                 '{`CRS_OFF_IDX1, 32'hFF800001, 32'h00800001},
                 '{`CRS_OFF_IDX2, 32'h007FFFFF, 32'h007FFFFF},
                 '{`CRS_OFF_IDX3, 32'h12345678, 32'h00345678},
                 '{`CRS_OFF_PC, 32'hFFFFFFFF, 32'h00007FFF},
                 '{`CRS_OFF_FLAG, 32'hFFFFFFFF, 32'h0000003F},
                 '{`CRS_OFF_OPND, 32'hFFFFFFFF, 32'h00FFFFFF},
                 '{`CRS_OFF_MADDR, 32'hFFFFFFFF, 32'h00007FFF}};
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        // Reset in mid-run clears what the table loaded
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        foreach (rows[i]) rd(rows[i].a, 32'h0);
        rd(`CRS_OFF_MEMCFG, MW - 1);
        // Two flag bits set, then one of them cleared
        wr(`CRS_OFF_FLGSET, 32'h21);
        rd(`CRS_OFF_FLAG, 32'h21);
        wr(`CRS_OFF_FLGCLR, 32'h20);
        rd(`CRS_OFF_FLAG, 32'h01);
        check({26'h0, flag_out}, 32'h01);
        // Installed size cut to 16 words; 45 lies beyond it and aliases location 5
        wr(`CRS_OFF_MEMCFG, 32'hF);
        aim(32'h5);
        rd(`CRS_OFF_INSN, 32'h0);
        wr(`CRS_OFF_OPND, 32'h00123457);
        run(32'h2);
        check(st & 32'h5, 32'h0);
        rd(`CRS_OFF_MADDR, 32'h5);
        rd(`CRS_OFF_PC, 32'h1);
        aim(32'h45);
        wr(`CRS_OFF_OPND, 32'h00654321);
        run(32'h2);
        check(st & 32'h4, 32'h4);
        // Load through a word whose code field is all ones
        aim(32'h001F8005);
        run(32'h1);
        check(st & 32'h5, 32'h0);
        rd(`CRS_OFF_INSN, 32'h001F8005);
        rd(`CRS_OFF_OPC, 32'h3F);
        rd(`CRS_OFF_OPND, 32'h00123457);
        rd(`CRS_OFF_ACC, 32'h00123457);
        // Floating store copies the low 15 bits of both accumulators
        wr(`CRS_OFF_EXT, 32'h00ABCDEF);
        aim(32'h45);
        run(32'h6);
        rd(`CRS_OFF_FPA, 32'h3457);
        rd(`CRS_OFF_FPB, 32'h4DEF);
        rd(`CRS_OFF_CMD, 32'h0);
        aim(32'h45);
        run(32'h1);
        check(st & 32'h4, 32'h4);
        rd(`CRS_OFF_OPND, 32'h0);
        rd(`CRS_OFF_ACC, 32'h0);
        // Counter wraps from the top address to zero
        wr(`CRS_OFF_PC, 32'h7FFF);
        run(32'h3);
        rd(`CRS_OFF_PC, 32'h0);
        // Interrupt masked, then enabled, then cleared
        check({31'h0, irq}, 32'h0);
        wr(`CRS_OFF_IRQ_EN, 32'h2);
        run(32'h3);
        check({31'h0, irq}, 32'h1);
        wr(`CRS_OFF_IRQ_CLR, 32'h2);
        rd(`CRS_OFF_IRQ_STAT, 32'h0);
        check({31'h0, irq}, 32'h0);
        // Unmapped place ignores writes and reads as zero
        wr(8'h80, 32'hFFFFFFFF);
        rd(8'h80, 32'h0);
        rd(`CRS_OFF_PC, 32'h1);
        conclude();
    end
endmodule
`default_nettype wire
